// *** bench/ebu_far_side.sv ***
// External memory model with a programmable ready reply.
`timescale 1ns/1ps
module ebu_far_side (
	input wire logic i_clock, // Clock.
	input wire logic i_ale, // Address strobe.
	input wire logic i_rd_n, // Read strobe.
	input wire logic i_wr_n, // Write strobe.
	input wire logic [15:0] i_addr, // Address seen.
	input wire logic [15:0] i_data, // Data seen.
	input wire logic [3:0] i_ready_delay, // Cycles until ready.
	input wire logic i_ready_pol, // Active ready level.
	output logic [15:0] o_data, // Data driven.
	output logic o_ready // Ready pin.
);
	logic [15:0] mem [16];
	logic [3:0] idx;
	logic [3:0] cnt = 4'h0;
	logic [15:0] junk = 16'hA5C3;
	// Latch the word address, store writes, count strobe cycles.
	always @(posedge i_clock) begin
		junk <= ~junk;
		if (i_ale) begin
			idx <= i_addr[4:1];
		end
		if (!i_wr_n) begin
			mem[idx] <= i_data;
		end
		cnt <= (i_rd_n && i_wr_n) ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
	end
	// Data only under the read strobe; a changing pattern otherwise.
	assign o_data = i_rd_n ? junk : mem[idx];
	// Ready stays inactive until the delay has run out.
	assign o_ready = (cnt >= i_ready_delay) ? i_ready_pol : !i_ready_pol;
endmodule : ebu_far_side

// *** bench/external_bus_unit_props.sv ***
// Port checks of the external bus unit.
`timescale 1ns/1ps
module ebu_checker (
	input wire logic i_clock, // Clock.
	input wire logic i_rst, // Reset.
	input wire logic [2:0] i_bus_mode, // Mode.
	input wire logic [1:0] i_addr_space, // Space.
	input wire logic i_chipselect_timing_select, // Select timing.
	input wire logic i_hold_ack_direction_bit, // Slave mode.
	input wire logic o_ale, // Strobe.
	input wire logic [4:0] o_chip_select_n, // Selects.
	input wire logic o_ctrl_oe_n, // Control enable.
	input wire logic [7:0] o_seg_addr_oe_n, // Segment enables.
	input wire logic o_dedicated_address_port_oe_n, // Address enable.
	input wire logic [1:0] o_address_data_port_oe_n, // Data enables.
	input wire logic o_hold_acknowledge_n, // Grant out.
	input wire logic o_hold_acknowledge_oe_n // Grant enable.
);
	// Segment line enables for each space code.
	localparam logic [7:0] SEG_OE [4] = '{8'h00, 8'hF0, 8'hFC, 8'hFF};
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// ----------
	// Properties
	// ----------
	sequence s_sel_fall;
		$fell(&o_chip_select_n);
	endsequence
	property p_no_single; $rose(o_ale) |-> $past(i_bus_mode) inside {3'h1, 3'h2, 3'h3, 3'h4}; endproperty
	a_no_single: assert property (p_no_single) else $error("cycle in single mode");
	property p_one_select; $onehot0(~o_chip_select_n); endproperty
	a_one_select: assert property (p_one_select) else $error("two selects low");
	property p_cs_early; s_sel_fall |-> !i_chipselect_timing_select || $rose(o_ale); endproperty
	a_cs_early: assert property (p_cs_early) else $error("select off strobe");
	property p_cs_late; s_sel_fall |-> i_chipselect_timing_select || ($past(o_ale) && !$rose(o_ale)); endproperty
	a_cs_late: assert property (p_cs_late) else $error("select not lagging");
	property p_slave_in; i_hold_ack_direction_bit && $past(i_hold_ack_direction_bit) |-> o_hold_acknowledge_oe_n; endproperty
	a_slave_in: assert property (p_slave_in) else $error("grant pin driven");
	property p_grant_float; !o_hold_acknowledge_n && !o_hold_acknowledge_oe_n |-> o_ctrl_oe_n && (&o_address_data_port_oe_n); endproperty
	a_grant_float: assert property (p_grant_float) else $error("bus driven when granted");
	property p_seg_lines; !o_ctrl_oe_n && $stable(i_addr_space) |-> o_seg_addr_oe_n == SEG_OE[i_addr_space]; endproperty
	a_seg_lines: assert property (p_seg_lines) else $error("segment lines wrong");
	property p_demux; !o_ctrl_oe_n && $stable(i_bus_mode) |-> o_dedicated_address_port_oe_n == !(i_bus_mode inside {3'h1, 3'h4}); endproperty
	a_demux: assert property (p_demux) else $error("address port wrong");
endmodule : ebu_checker
bind external_bus_unit ebu_checker ebu_checker_inst (.i_clock, .i_rst, .i_bus_mode, .i_addr_space,
	.i_chipselect_timing_select, .i_hold_ack_direction_bit, .o_ale, .o_chip_select_n, .o_ctrl_oe_n,
	.o_seg_addr_oe_n, .o_dedicated_address_port_oe_n, .o_address_data_port_oe_n,
	.o_hold_acknowledge_n, .o_hold_acknowledge_oe_n);

// *** bench/external_bus_unit_tb.sv ***
// Self-checking bench of the external bus unit.
`timescale 1ns/1ps
module external_bus_unit_tb;
	logic i_clock = 1'b0, i_rst = 1'b1, i_chipselect_timing_select = 1'b0;
	logic i_hold_arbitration_enable = 1'b0, i_hold_ack_direction_bit = 1'b0;
	logic i_req = 1'b0, i_we = 1'b0, i_hold_n = 1'b1, i_hold_acknowledge_n = 1'b1;
	logic [2:0] i_bus_mode = 3'h1;
	logic [1:0] i_addr_space = 2'h0;
	logic [79:0] i_window_bus_config = {5{16'h0203}};
	logic [23:0] i_addr = 24'h0;
	logic [15:0] i_wdata = 16'h0;
	logic [3:0] ready_delay = 4'h0;
	logic o_ack, o_err, o_ale, o_rd_n, o_wr_n, o_ctrl_oe_n, o_dedicated_address_port_oe_n, ready;
	logic o_bus_request_out_n, o_hold_acknowledge_n, o_hold_acknowledge_oe_n;
	logic [15:0] o_rdata, o_dedicated_address_port, o_address_data_port, far_data, pin;
	logic [1:0] o_address_data_port_oe_n;
	logic [4:0] o_chip_select_n, sel;
	logic [7:0] seg;
	int cycles = 0, error_cnt = 0, checks_done = 0, cyc;
	// Pin level per byte from whichever side drives it.
	assign pin = {o_address_data_port_oe_n[1] ? far_data[15:8] : o_address_data_port[15:8],
		o_address_data_port_oe_n[0] ? far_data[7:0] : o_address_data_port[7:0]};
	external_bus_unit external_bus_unit_inst (.i_clock, .i_rst, .i_bus_mode, .i_addr_space,
		.i_chipselect_timing_select, .i_hold_arbitration_enable, .i_hold_ack_direction_bit,
		.i_window_address_select({12'h024, 12'h020, 12'h018, 12'h010}), .i_window_size(16'h0404),
		.i_window_bus_config, .i_req, .i_we, .i_addr, .i_wdata, .o_ack, .o_err, .o_rdata,
		.o_dedicated_address_port, .o_dedicated_address_port_oe_n, .o_seg_addr(seg), .o_seg_addr_oe_n(),
		.i_address_data_port(pin), .o_address_data_port, .o_address_data_port_oe_n, .o_ale, .o_rd_n,
		.o_wr_n, .o_ctrl_oe_n, .o_chip_select_n, .i_ready(ready), .i_hold_n, .o_bus_request_out_n,
		.i_hold_acknowledge_n, .o_hold_acknowledge_n, .o_hold_acknowledge_oe_n);
	ebu_far_side ebu_far_side_inst (.i_clock, .i_ale(o_ale), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
		.i_addr(o_dedicated_address_port_oe_n ? pin : o_dedicated_address_port), .i_data(pin),
		.i_ready_delay(ready_delay), .i_ready_pol(i_window_bus_config[8]), .o_data(far_data),
		.o_ready(ready));
	// Clock and hang limit.
	initial begin
		forever begin
			#25 i_clock = ~i_clock;
		end
	end
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			stop_test();
		end
	end
	// ---------
	// Utilities
	// ---------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	// One access; holds the request until acknowledged, merging selects seen.
	task automatic acc(input logic we, input logic [23:0] a, input logic [15:0] d);
		cyc = 0;
		sel = 5'h1F;
		@(negedge i_clock);
		i_req = 1'b1;
		i_we = we;
		i_addr = a;
		i_wdata = d;
		while (o_ack !== 1'b1 && cyc < 100) begin
			@(negedge i_clock);
			cyc++;
			sel &= o_chip_select_n;
		end
		i_req = 1'b0;
	endtask : acc
	// ---------
	// Scenarios
	// ---------
	task automatic t_modes();
		for (int m = 1; m < 5; m++) begin
			i_bus_mode = 3'(m);
			i_addr_space = 2'(m - 1);
			acc(1'b1, 24'h000010 + 24'(2 * m), 16'hC35A + 16'(m));
			acc(1'b1, 24'h000030, 16'h0000);
			acc(1'b0, 24'h000010 + 24'(2 * m), 16'h0000);
			check("read back", o_rdata, (m > 2) ? {8'h00, 8'h5A + 8'(m)} : 16'hC35A + 16'(m));
		end
	endtask : t_modes
	// Upper address lines are cut to the selected space.
	task automatic t_space();
		logic [7:0] want [4] = '{8'hFF, 8'h0F, 8'h03, 8'h00};
		i_bus_mode = 3'h1;
		for (int s = 0; s < 4; s++) begin
			i_addr_space = 2'(s);
			acc(1'b0, 24'hFF0040, 16'h0000);
			check("segment lines", 16'(seg), 16'(want[s]));
		end
	endtask : t_space
	task automatic t_windows();
		logic [23:0] adr [4] = '{24'h018010, 24'h024010, 24'h030000, 24'h010010};
		logic [4:0] want [4] = '{5'h1B, 5'h0F, 5'h1E, 5'h1D};
		i_bus_mode = 3'h2;
		i_addr_space = 2'h0;
		for (int k = 0; k < 4; k++) begin
			i_chipselect_timing_select = k[0];
			acc(1'b1, adr[k], 16'h1234);
			check("window select", 16'(sel), 16'(want[k]));
		end
	endtask : t_windows
	task automatic t_ready();
		for (int p = 0; p < 2; p++) begin
			i_window_bus_config[15:0] = {6'h00, 1'b1, p[0], 8'h83};
			ready_delay = 4'h9;
			acc(1'b1, 24'h000040, 16'h0F0F);
			check("ready stretch", 16'(cyc > 10), 16'h0001);
			ready_delay = 4'h0;
		end
		i_window_bus_config[15:0] = 16'h0203;
	endtask : t_ready
	task automatic t_arbitrate(input logic slave);
		@(negedge i_clock);
		i_hold_arbitration_enable = 1'b1;
		i_hold_ack_direction_bit = slave;
		i_hold_n = slave;
		repeat (6) @(negedge i_clock);
		check("grant enable", 16'(o_hold_acknowledge_oe_n), 16'(slave));
		if (!slave) begin
			check("grant", 16'(o_hold_acknowledge_n), 16'h0000);
		end
		fork
			acc(1'b1, 24'h000050, 16'h5A5A);
			begin
				repeat (8) @(negedge i_clock);
				check("request", 16'(o_bus_request_out_n), 16'h0000);
				check("deferred", 16'(o_ack), 16'h0000);
				i_hold_n = 1'b1;
				i_hold_acknowledge_n = !slave;
			end
		join
		check("done after release", 16'(o_ack), 16'h0001);
	endtask : t_arbitrate
	// Main sequence.
	initial begin
		repeat (4) @(negedge i_clock);
		i_rst = 1'b0;
		check("grant after reset", 16'(o_hold_acknowledge_n), 16'h0001);
		i_bus_mode = 3'h0;
		acc(1'b0, 24'h000020, 16'h0000);
		check("refused", 16'(o_err), 16'h0001);
		check("no select", 16'(sel), 16'h001F);
		t_modes();
		t_space();
		t_windows();
		t_ready();
		t_arbitrate(1'b0);
		t_arbitrate(1'b1);
		stop_test();
	end
endmodule : external_bus_unit_tb

// *** hw/ebu_defs.svh ***
// Constants of the external bus unit.
`ifndef EBU_DEFS_SVH
`define EBU_DEFS_SVH
// Bus configuration word fields.
`define CFG_WAIT_LSB 0
`define CFG_WAIT_MSB 3
`define CFG_TRI 4
`define CFG_ALE 5
`define CFG_RWDLY 6
`define CFG_RDYEN 7
`define CFG_READY_POLARITY 8
`define CFG_CSEN 9
// Window select: size code k up to WIN_SIZE_MAX spans 4 Kbytes shifted left by k, larger codes 4 Kbytes.
`define WIN_BASE_LSB 12
`define WIN_SIZE_MAX 4'hB
// Timing: chip-select lag of half a CPU clock, CPU clock period in ns.
`define CPU_CLK_NS 100
`define SYS_CLK_NS 50
`define CS_LAG_CYC (((`CPU_CLK_NS / 2) + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define NUM_WIN 4
`define NUM_CS 5
`endif

// *** hw/ebu_pkg.sv ***
// Types of the external bus unit.
package ebu_pkg;
	typedef enum logic [2:0] {
		MODE_SINGLE = 3'h0,
		MODE_DEMUX16 = 3'h1,
		MODE_MUX16 = 3'h2,
		MODE_MUX8 = 3'h3,
		MODE_DEMUX8 = 3'h4
	} bus_mode_e;
	typedef enum logic [1:0] {
		SPACE_16M = 2'h0,
		SPACE_1M = 2'h1,
		SPACE_256K = 2'h2,
		SPACE_64K = 2'h3
	} addr_space_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_DELAY = 3'h2,
		ST_DATA = 3'h3,
		ST_TRI = 3'h4
	} bus_state_e;
	typedef struct packed {
		bus_state_e st;
		logic [3:0] cnt;
		logic [2:0] win;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic we;
		logic [15:0] rdata;
		logic ack;
		logic err;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic [4:0] cs_n;
		logic [1:0] cs_lag;
		logic [1:0] hold_sy;
		logic [1:0] rdy_sy;
		logic [1:0] hak_sy;
		logic [31:0] ad_sy;
		logic granted;
		logic bus_request_out_n;
	} ebu_state_s;
endpackage : ebu_pkg

// *** hw/external_bus_unit.sv ***
// External bus unit: windows, chip selects, bus cycles and hold arbitration.
`timescale 1ns/1ps
`include "ebu_defs.svh"
module external_bus_unit (
	input wire logic i_clock, // System clock, 20 MHz.
	input wire logic i_rst, // Synchronous reset, active high.
	// Configuration.
	input wire logic [2:0] i_bus_mode, // Bus mode code.
	input wire logic [1:0] i_addr_space, // Address space limit code.
	input wire logic i_chipselect_timing_select, // Chip selects move with strobe.
	input wire logic i_hold_arbitration_enable, // Arbitration on.
	input wire logic i_hold_ack_direction_bit, // One selects slave mode.
	input wire logic [47:0] i_window_address_select, // Per window base[11:0].
	input wire logic [15:0] i_window_size, // Per window size code[3:0].
	input wire logic [79:0] i_window_bus_config, // Configs, 0 is default.
	// Internal access port.
	input wire logic i_req, // Access request level.
	input wire logic i_we, // Write when high.
	input wire logic [23:0] i_addr, // Byte address.
	input wire logic [15:0] i_wdata, // Write data.
	output logic o_ack, // Access done pulse.
	output logic o_err, // Refused access, with ack.
	output logic [15:0] o_rdata, // Read data.
	// Bus pins.
	output logic [15:0] o_dedicated_address_port, // Address out.
	output logic o_dedicated_address_port_oe_n, // Low while driven.
	output logic [7:0] o_seg_addr, // Segment address lines.
	output logic [7:0] o_seg_addr_oe_n, // Per line, low while driven.
	input wire logic [15:0] i_address_data_port, // Pin level in.
	output logic [15:0] o_address_data_port, // Pin drive value.
	output logic [1:0] o_address_data_port_oe_n, // Per byte, low drives.
	output logic o_ale, // Address latch strobe.
	output logic o_rd_n, // Read strobe.
	output logic o_wr_n, // Write strobe.
	output logic o_ctrl_oe_n, // Strobes and selects enable.
	output logic [4:0] o_chip_select_n, // Chip selects, 0 default.
	input wire logic i_ready, // Ready pin.
	input wire logic i_hold_n, // Hold request pin.
	output logic o_bus_request_out_n, // Bus request pin.
	input wire logic i_hold_acknowledge_n, // Acknowledge pin in.
	output logic o_hold_acknowledge_n, // Acknowledge pin out.
	output logic o_hold_acknowledge_oe_n // Low while driven.
);

	// ------------------------------------------------------------
	// Operation
	// ------------------------------------------------------------

	// The unit turns one internal access into one external bus cycle.
	// A request is taken only while the state is idle, the bus is owned,
	// no hold is pending and no acknowledge went out in the last cycle.
	// The acknowledge of one access therefore also spaces the next one.
	//
	// The address is first trimmed to the selected space limit.
	// The trimmed address then picks a window or the default region.
	// Window, address, direction and write data are latched when taken.
	// All later timing reads the latched window's configuration word.
	// A configuration change during a cycle applies to its remaining states, but not to a strobe length or wait count already loaded.
	//
	// A cycle walks through up to five states:
	// idle, address phase, optional strobe delay, data phase, dead cycle.
	// The address phase lasts one cycle, or two with a long strobe.
	// The data phase lasts the wait count plus one cycle at the least.
	// With ready enabled, the data phase then waits for the ready level.
	// Ready passes a two-stage synchroniser, so it acts two cycles late.
	// A slow device must account for that lag in its own reply.
	//
	// Read data also passes a two-stage synchroniser before capture.
	// The captured word is the pin level two cycles before the end.
	// A slow device needs wait states so that its data is stable then.
	// In the 8-bit modes the upper byte of the read result is zero.
	// In the 8-bit modes the upper byte of the port is driven only in the MUX8 address phase.
	//
	// Chip selects follow either the strobe edge or a lagged update.
	// The lag is counted in system clocks from the strobe rise.
	// One system clock stands for half a CPU clock here.
	// A window with its select disabled keeps every select high.
	// Selects are released in the same edge as the acknowledge.
	//
	// Arbitration runs only while the enable input is high.
	// In master mode a synchronised hold request gives the bus away.
	// The bus is handed over only between cycles, never inside one.
	// While granted, every bus output enable but the acknowledge pin's stays high.
	// A pending own access then drives the bus request pin low.
	// In slave mode the acknowledge pin is read, not driven.
	// The unit owns the bus only while that pin is seen low.
	//
	// Single-chip mode starts no cycle at all.
	// A request there is answered at once with the error flag.
	// Unknown mode codes are treated as single-chip mode.
	// All bus outputs but the acknowledge and bus request pins stay released, so the pins can serve as ports.
	//
	// Outputs come straight from the state register, except the address/data port value,
	// which also follows the mode, and the output enables, which follow ownership, mode, space code and arbitration setting.
	// Reset is synchronous and clears the grant; master or slave mode follows the direction input.
	// The hold and acknowledge synchronisers reset to the idle levels of their pins,
	// so no false hold or grant is seen after reset.

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Window hit: compare address bits above the window size.
	function automatic logic win_hit(
		input logic [23:0] a,
		input logic [11:0] base,
		input logic [3:0] size
	);
		logic [11:0] mask;
		mask = 12'hFFF;
		if (size <= `WIN_SIZE_MAX) begin
			mask = 12'hFFF << size;
		end
		win_hit = ((a[23:`WIN_BASE_LSB] ^ base) & mask) == 12'h000;
	endfunction : win_hit

	// Mask of segment lines in use for each address space.
	function automatic logic [7:0] seg_lines(input logic [1:0] sp);
		seg_lines = 8'hFF;
		unique case (ebu_pkg::addr_space_e'(sp))
			ebu_pkg::SPACE_16M: seg_lines = 8'hFF;
			ebu_pkg::SPACE_1M: seg_lines = 8'h0F;
			ebu_pkg::SPACE_256K: seg_lines = 8'h03;
			ebu_pkg::SPACE_64K: seg_lines = 8'h00;
		endcase
	endfunction : seg_lines

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------

	ebu_pkg::ebu_state_s s_reg;
	ebu_pkg::ebu_state_s s_next;
	ebu_pkg::bus_mode_e mode;
	logic [2:0] sel;
	logic [9:0] cfg;
	logic [23:0] addr_lim;
	logic [4:0] cs_vec;
	logic single;
	logic mux;
	logic narrow;
	logic own;
	logic hold_pend;
	logic rdy_ok;

	assign mode = ebu_pkg::bus_mode_e'(i_bus_mode);
	assign single = !(mode inside {ebu_pkg::MODE_DEMUX16, ebu_pkg::MODE_MUX16,
		ebu_pkg::MODE_MUX8, ebu_pkg::MODE_DEMUX8});
	assign mux = (mode == ebu_pkg::MODE_MUX16) || (mode == ebu_pkg::MODE_MUX8);
	assign narrow = (mode == ebu_pkg::MODE_MUX8) || (mode == ebu_pkg::MODE_DEMUX8);
	// Upper lines beyond the space limit are cleared.
	assign addr_lim = {i_addr[23:16] & seg_lines(i_addr_space), i_addr[15:0]};

	// Window select, later windows checked last so they win.
	always_comb begin
		sel = 3'h0;
		for (int w = 0; w < `NUM_WIN; w++) begin
			if (win_hit(addr_lim, i_window_address_select[w*12 +: 12],
				i_window_size[w*4 +: 4])) begin
				sel = 3'(w + 1);
			end
		end
	end

	// Configuration of the window of the cycle in progress.
	assign cfg = i_window_bus_config[s_reg.win*16 +: 10];
	// Chip select of the latched window, if enabled there.
	assign cs_vec = ~(5'(cfg[`CFG_CSEN]) << s_reg.win);
	// Ready compared against the window polarity.
	assign rdy_ok = !cfg[`CFG_RDYEN] || (s_reg.rdy_sy[1] == cfg[`CFG_READY_POLARITY]);

	// Ownership: master owns unless granted away, slave owns once granted.
	assign own = i_hold_ack_direction_bit && i_hold_arbitration_enable ?
		!s_reg.hak_sy[1] : !s_reg.granted;
	assign hold_pend = i_hold_arbitration_enable && !i_hold_ack_direction_bit &&
		!s_reg.hold_sy[1];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	always_comb begin
		s_next = s_reg;
		s_next.ack = 1'b0;
		s_next.err = 1'b0;
		// Pin synchronisers.
		s_next.hold_sy = {s_reg.hold_sy[0], i_hold_n};
		s_next.rdy_sy = {s_reg.rdy_sy[0], i_ready};
		s_next.hak_sy = {s_reg.hak_sy[0], i_hold_acknowledge_n};
		s_next.ad_sy = {s_reg.ad_sy[15:0], i_address_data_port};
		// Deferred chip-select update after the strobe rises.
		if (s_reg.cs_lag != 2'h0) begin
			s_next.cs_lag = s_reg.cs_lag - 2'h1;
			if (s_reg.cs_lag == 2'h1) begin
				s_next.cs_n = cs_vec;
			end
		end

		// Master side: give the bus away only between cycles.
		if (!hold_pend) begin
			s_next.granted = 1'b0;
		end else if (s_reg.st == ebu_pkg::ST_IDLE) begin
			s_next.granted = 1'b1;
		end

		// Bus request: master asks back while granted, slave asks to own.
		if (!i_hold_arbitration_enable) begin
			s_next.bus_request_out_n = 1'b1;
		end else if (i_hold_ack_direction_bit) begin
			s_next.bus_request_out_n = !(i_req && !single) && (s_reg.st == ebu_pkg::ST_IDLE);
		end else begin
			s_next.bus_request_out_n = !(s_reg.granted && i_req && !single);
		end

		unique case (s_reg.st)
			ebu_pkg::ST_IDLE: begin
				if (i_req && !s_reg.ack) begin
					if (single) begin
						// No external cycle at all.
						s_next.ack = 1'b1;
						s_next.err = 1'b1;
					end else if (own && !hold_pend && !s_reg.granted) begin
						s_next.st = ebu_pkg::ST_ADDR;
						s_next.addr = addr_lim;
						s_next.we = i_we;
						s_next.wdata = i_wdata;
						s_next.win = sel;
						s_next.cnt = 4'(i_window_bus_config[sel*16 + `CFG_ALE]);
						s_next.ale = 1'b1;
						if (i_chipselect_timing_select) begin
							s_next.cs_n = ~(5'(i_window_bus_config[sel*16 + `CFG_CSEN])
								<< sel);
						end else begin
							s_next.cs_lag = 2'(`CS_LAG_CYC);
						end
					end
				end
			end
			ebu_pkg::ST_ADDR: begin
				// Strobe length: one or two cycles.
				if (s_reg.cnt != 4'h0) begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end else begin
					s_next.ale = 1'b0;
					s_next.cnt = cfg[`CFG_WAIT_MSB:`CFG_WAIT_LSB];
					if (cfg[`CFG_RWDLY]) begin
						s_next.st = ebu_pkg::ST_DELAY;
					end else begin
						s_next.st = ebu_pkg::ST_DATA;
						s_next.rd_n = s_reg.we;
						s_next.wr_n = !s_reg.we;
					end
				end
			end
			ebu_pkg::ST_DELAY: begin
				// Read/write strobe delayed by one cycle.
				s_next.st = ebu_pkg::ST_DATA;
				s_next.rd_n = s_reg.we;
				s_next.wr_n = !s_reg.we;
			end
			ebu_pkg::ST_DATA: begin
				if (s_reg.cnt != 4'h0) begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end else if (rdy_ok) begin
					s_next.rd_n = 1'b1;
					s_next.wr_n = 1'b1;
					s_next.cs_n = 5'h1F;
					s_next.cs_lag = 2'h0;
					s_next.ack = 1'b1;
					s_next.rdata = narrow ? {8'h00, s_reg.ad_sy[23:16]} : s_reg.ad_sy[31:16];
					s_next.st = cfg[`CFG_TRI] ? ebu_pkg::ST_TRI : ebu_pkg::ST_IDLE;
				end
			end
			ebu_pkg::ST_TRI: begin
				// One dead cycle before the next address phase.
				s_next.st = ebu_pkg::ST_IDLE;
			end
			default: begin
				s_next.st = ebu_pkg::ST_IDLE;
			end
		endcase

		if (i_rst) begin
			s_next = '0;
			s_next.st = ebu_pkg::ST_IDLE;
			s_next.rd_n = 1'b1;
			s_next.wr_n = 1'b1;
			s_next.cs_n = 5'h1F;
			s_next.bus_request_out_n = 1'b1;
			s_next.hold_sy = 2'h3;
			s_next.hak_sy = 2'h3;
		end
	end

	// State register.
	always_ff @(posedge i_clock) begin
		s_reg <= s_next;
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------

	logic drive;
	logic in_cycle;
	logic data_out;

	// Bus is driven only when owned and not in single-chip mode.
	assign drive = own && !single && !s_reg.granted;
	assign in_cycle = s_reg.st != ebu_pkg::ST_IDLE;
	assign data_out = s_reg.we && in_cycle && (s_reg.st != ebu_pkg::ST_ADDR)
		&& (s_reg.st != ebu_pkg::ST_TRI);

	assign o_ack = s_reg.ack;
	assign o_err = s_reg.err;
	assign o_rdata = s_reg.rdata;
	// Dedicated address port carries the address in demux modes.
	assign o_dedicated_address_port = s_reg.addr[15:0];
	assign o_dedicated_address_port_oe_n = !(drive && !mux);
	assign o_seg_addr = s_reg.addr[23:16];
	assign o_seg_addr_oe_n = drive ? ~seg_lines(i_addr_space) : 8'hFF;
	// Address phase in mux modes, then data on the same lines.
	assign o_address_data_port = (mux && s_reg.st == ebu_pkg::ST_ADDR) ?
		s_reg.addr[15:0] : s_reg.wdata;
	always_comb begin
		o_address_data_port_oe_n = 2'h3;
		if (drive && mux && s_reg.st == ebu_pkg::ST_ADDR) begin
			o_address_data_port_oe_n = 2'h0;
		end else if (drive && data_out) begin
			o_address_data_port_oe_n = narrow ? 2'h2 : 2'h0;
		end
	end
	assign o_ale = s_reg.ale;
	assign o_rd_n = s_reg.rd_n;
	assign o_wr_n = s_reg.wr_n;
	assign o_ctrl_oe_n = !drive;
	assign o_chip_select_n = s_reg.cs_n;
	assign o_bus_request_out_n = s_reg.bus_request_out_n;
	// Acknowledge is an output in master mode with arbitration enabled, and an input in slave mode.
	assign o_hold_acknowledge_n = !s_reg.granted;
	assign o_hold_acknowledge_oe_n = i_hold_ack_direction_bit ||
		!i_hold_arbitration_enable;

endmodule : external_bus_unit
